// File: design/scan_hit_pkg.sv
package scan_hit_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int WORD_W = 16;
	localparam int CHAN_N = 32;
	// register byte addresses
	localparam logic [ADDR_W-1:0] HIT_LOW_ADDR    = 8'h00;
	localparam logic [ADDR_W-1:0] SCAN_HIGH_ADDR  = 8'h04;
	localparam logic [ADDR_W-1:0] SCAN_LOW_ADDR   = 8'h08;
	localparam logic [ADDR_W-1:0] CHARGE_HIGH_ADDR = 8'h0C;
	localparam logic [ADDR_W-1:0] CHARGE_LOW_ADDR = 8'h10;
	localparam logic [ADDR_W-1:0] CONTROL_ADDR    = 8'h14;
	localparam logic [ADDR_W-1:0] STATUS_ADDR     = 8'h18;
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 8'h1C;
	localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR  = 8'h20;
	// writable masks of the channel words
	localparam logic [WORD_W-1:0] HIT_LOW_MASK     = 16'hFFFF;
	localparam logic [WORD_W-1:0] SCAN_HIGH_MASK   = 16'h7CFF;
	localparam logic [WORD_W-1:0] SCAN_LOW_MASK    = 16'hFFFF;
	localparam logic [WORD_W-1:0] CHARGE_HIGH_MASK = 16'h00FF;
	localparam logic [WORD_W-1:0] CHARGE_LOW_MASK  = 16'hFFFF;
	localparam logic [WORD_W-1:0] WORD_RESET       = 16'h0000;
	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DIV_LSB  = 8;
	localparam int CTRL_SCAN_BIT = 16;
	localparam int CTRL_START_BIT = 17;
	localparam int DIV_W = 8;
	localparam int CONV_TADS = 12;
	localparam int SAMPLE_TADS = 1;
	localparam int EVENT_N = 3;
	localparam int EV_DONE = 0;
	localparam int EV_HIT = 1;
	localparam int EV_SCAN_END = 2;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		CMP_LESS,
		CMP_GREATER,
		CMP_INSIDE,
		CMP_OUTSIDE
	} cmp_mode_type;
endpackage : scan_hit_pkg

// File: design/conv_link_if.sv
`timescale 1ns/1ns
interface conv_link_if;
	logic        tad_tick;
	logic [7:0]  divider;
	logic        enable;
	modport source (input tad_tick, output divider, output enable);
	modport divider_end (output tad_tick, input divider, input enable);
endinterface : conv_link_if

// File: design/tad_divider.sv
`timescale 1ns/1ns
module tad_divider
	import scan_hit_pkg::*;
(
	input  wire logic  ref_clk_i,
	input  wire logic  rst_n_i,
	conv_link_if.divider_end link
);
	logic [DIV_W-1:0] count_q;
	logic [DIV_W-1:0] count_d;
	logic             tick_q;
	logic             tick_d;

	always_comb begin
		count_d = count_q;
		tick_d  = 1'b0;
		if (!link.enable) begin
			count_d = '0;
		end else if (count_q >= link.divider) begin
			count_d = '0;
			tick_d  = 1'b1;
		end else begin
			count_d = count_q + 8'h01;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= '0;
			tick_q  <= 1'b0;
		end else begin
			count_q <= count_d;
			tick_q  <= tick_d;
		end
	end

	assign link.tad_tick = tick_q;
endmodule : tad_divider

// File: design/hit_compare.sv
`timescale 1ns/1ns
module hit_compare
	import scan_hit_pkg::*;
(
	input  wire cmp_mode_type   mode_i,
	input  wire logic [11:0]    result_i,
	input  wire logic [11:0]    low_bound_i,
	input  wire logic [11:0]    high_bound_i,
	input  wire logic           written_i,
	output logic                hit_o
);
	always_comb begin
		case (mode_i)
			CMP_LESS:    hit_o = written_i && (result_i < low_bound_i);
			CMP_GREATER: hit_o = written_i && (result_i > low_bound_i);
			CMP_INSIDE:  hit_o = written_i && (result_i >= low_bound_i)
				&& (result_i <= high_bound_i);
			CMP_OUTSIDE: hit_o = written_i;
			default:     hit_o = 1'b0;
		endcase
	end
endmodule : hit_compare

// File: design/scan_hit_ctrl.sv
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
// What this block does
// - outside mode flags any write or match
// - other modes flag only valid matches
// - unimplemented channel bits read zero
// - scan high word maps channels 30-26, 23-16
// - scan includes selected inputs, skips others
// - charge unit connects to enabled converting channel
// - upper byte of charge high word reads zero
// - sampling completes before conversion starts
// - at least one clock period sampling
// - hold capacitor discharged before sampling
// - compare mode two-bit encoding
// - conversion clock is cycle times divider+1
module scan_hit_ctrl
	import scan_hit_pkg::*;
#(
	parameter logic [CHAN_N-1:0] IMPL_MASK = 32'h7CFF_FFFF
) (
	input  wire logic                 ref_clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [DATA_W-1:0]    s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [11:0]          result_i,
	input  wire logic [11:0]          low_bound_i,
	input  wire logic [11:0]          high_bound_i,
	output logic [4:0]                channel_o,
	output logic                      sample_o,
	output logic                      discharge_o,
	output logic                      convert_o,
	output logic                      charge_unit_o,
	output logic                      result_write_o,
	output logic                      irq_o
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DISCHARGE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_ADVANCE,
		ST_NEXT
	} seq_type;

	function automatic logic [WORD_W-1:0] merge(
		input logic [WORD_W-1:0] old_v,
		input logic [DATA_W-1:0] data,
		input logic [3:0]        strb,
		input logic [WORD_W-1:0] mask
	);
		logic [WORD_W-1:0] v;
		v = old_v;
		if (strb[0]) v[7:0] = data[7:0];
		if (strb[1]) v[15:8] = data[15:8];
		return v & mask;
	endfunction : merge

	conv_link_if link ();

	logic [WORD_W-1:0]  hit_q, hit_d;
	logic [WORD_W-1:0]  scan_hi_q, scan_hi_d, scan_lo_q, scan_lo_d;
	logic [WORD_W-1:0]  chg_hi_q, chg_hi_d, chg_lo_q, chg_lo_d;
	logic [1:0]         mode_q, mode_d;
	logic [DIV_W-1:0]   div_q, div_d;
	logic               scan_en_q, scan_en_d;
	logic [EVENT_N-1:0] stat_q, stat_d, irq_en_q, irq_en_d;
	logic               aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d, wr_q, wr_d;
	logic [ADDR_W-1:0]  awaddr_q, awaddr_d;
	logic [DATA_W-1:0]  wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]         wstrb_q, wstrb_d, tads_q, tads_d;
	logic [1:0]         bresp_q, bresp_d, rresp_q, rresp_d;
	seq_type            st_q, st_d;
	logic [4:0]         ch_q, ch_d;
	logic               start_pulse, do_write, hit_now;
	logic [CHAN_N-1:0]  scan_map, chg_map;
	logic [EVENT_N-1:0] ev;

	assign scan_map = {1'b0, scan_hi_q[14:10], 2'b00, scan_hi_q[7:0],
		scan_lo_q} & IMPL_MASK;
	assign chg_map = {8'h00, chg_hi_q[7:0], chg_lo_q} & IMPL_MASK;

	assign link.divider = div_q;
	assign link.enable  = (st_q != ST_IDLE);

	tad_divider u_div (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.link      (link)
	);

	hit_compare u_cmp (
		.mode_i       (cmp_mode_type'(mode_q)),
		.result_i     (result_i),
		.low_bound_i  (low_bound_i),
		.high_bound_i (high_bound_i),
		.written_i    (wr_q),
		.hit_o        (hit_now)
	);

	assign do_write = aw_q && w_q && !b_q;

	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		b_d = b_q;
		r_d = r_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bresp_d = bresp_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		scan_hi_d = scan_hi_q;
		scan_lo_d = scan_lo_q;
		chg_hi_d = chg_hi_q;
		chg_lo_d = chg_lo_q;
		mode_d = mode_q;
		div_d = div_q;
		scan_en_d = scan_en_q;
		irq_en_d = irq_en_q;
		hit_d = hit_q;
		stat_d = stat_q;
		start_pulse = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (b_q && s_axi_bready) begin
			b_d = 1'b0;
		end
		if (do_write) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			b_d = 1'b1;
			bresp_d = RESP_OKAY;
			case (awaddr_q)
				HIT_LOW_ADDR: hit_d = merge(hit_q, wdata_q, wstrb_q,
					HIT_LOW_MASK & IMPL_MASK[15:0]);
				SCAN_HIGH_ADDR: scan_hi_d = merge(scan_hi_q, wdata_q,
					wstrb_q, SCAN_HIGH_MASK & IMPL_MASK[31:16]);
				SCAN_LOW_ADDR: scan_lo_d = merge(scan_lo_q, wdata_q,
					wstrb_q, SCAN_LOW_MASK & IMPL_MASK[15:0]);
				CHARGE_HIGH_ADDR: chg_hi_d = merge(chg_hi_q, wdata_q,
					wstrb_q, CHARGE_HIGH_MASK & IMPL_MASK[31:16]);
				CHARGE_LOW_ADDR: chg_lo_d = merge(chg_lo_q, wdata_q,
					wstrb_q, CHARGE_LOW_MASK & IMPL_MASK[15:0]);
				CONTROL_ADDR: begin
					if (wstrb_q[0]) mode_d = wdata_q[CTRL_MODE_LSB +: 2];
					if (wstrb_q[1]) div_d = wdata_q[CTRL_DIV_LSB +: DIV_W];
					if (wstrb_q[2]) begin
						scan_en_d = wdata_q[CTRL_SCAN_BIT];
						start_pulse = wdata_q[CTRL_START_BIT];
					end
				end
				IRQ_ENABLE_ADDR: if (wstrb_q[0]) irq_en_d = wdata_q[EVENT_N-1:0];
				IRQ_CLEAR_ADDR: if (wstrb_q[0])
					stat_d = stat_q & ~wdata_q[EVENT_N-1:0];
				STATUS_ADDR: bresp_d = RESP_OKAY;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		// valid match sets flag, set beats clear
		if (hit_now && ch_q < 5'd16 && IMPL_MASK[ch_q]) begin
			hit_d[ch_q[3:0]] = 1'b1;
		end
		stat_d = stat_d | ev;
		if (r_q && s_axi_rready) begin
			r_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			r_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			case (s_axi_araddr)
				HIT_LOW_ADDR:     rdata_d[15:0] = hit_q;
				SCAN_HIGH_ADDR:   rdata_d[15:0] = scan_hi_q;
				SCAN_LOW_ADDR:    rdata_d[15:0] = scan_lo_q;
				CHARGE_HIGH_ADDR: rdata_d[15:0] = chg_hi_q;
				CHARGE_LOW_ADDR:  rdata_d[15:0] = chg_lo_q;
				CONTROL_ADDR: begin
					rdata_d[CTRL_MODE_LSB +: 2] = mode_q;
					rdata_d[CTRL_DIV_LSB +: DIV_W] = div_q;
					rdata_d[CTRL_SCAN_BIT] = scan_en_q;
				end
				STATUS_ADDR:     rdata_d[EVENT_N-1:0] = stat_q;
				IRQ_ENABLE_ADDR: rdata_d[EVENT_N-1:0] = irq_en_q;
				IRQ_CLEAR_ADDR:  rdata_d = '0;
				default:         rresp_d = RESP_SLVERR;
			endcase
		end
	end

	// sequencer: discharge, sample, convert, advance
	always_comb begin
		st_d = st_q;
		ch_d = ch_q;
		tads_d = tads_q;
		wr_d = 1'b0;
		ev = '0;
		case (st_q)
			ST_IDLE: if (start_pulse) begin
				ch_d = '0;
				st_d = ST_NEXT;
			end
			ST_NEXT: begin
				if (scan_en_q && !scan_map[ch_q]) begin
					if (ch_q == 5'(CHAN_N - 1)) begin
						st_d = ST_IDLE;
						ev[EV_SCAN_END] = 1'b1;
					end else begin
						ch_d = ch_q + 5'd1;
					end
				end else begin
					st_d = ST_DISCHARGE;
				end
			end
			ST_DISCHARGE: if (link.tad_tick) begin
				st_d = ST_SAMPLE;
				tads_d = 4'(SAMPLE_TADS);
			end
			ST_SAMPLE: if (link.tad_tick) begin
				if (tads_q <= 4'd1) begin
					st_d = ST_CONVERT;
					tads_d = 4'(CONV_TADS);
				end else begin
					tads_d = tads_q - 4'd1;
				end
			end
			ST_CONVERT: if (link.tad_tick) begin
				if (tads_q <= 4'd1) begin
					wr_d = 1'b1;
					ev[EV_DONE] = 1'b1;
					if (scan_en_q && ch_q != 5'(CHAN_N - 1)) begin
						st_d = ST_ADVANCE;
					end else begin
						st_d = ST_IDLE;
						ev[EV_SCAN_END] = scan_en_q;
					end
				end else begin
					tads_d = tads_q - 4'd1;
				end
			end
			// channel moves only after the hit lands on its own flag
			ST_ADVANCE: begin
				ch_d = ch_q + 5'd1;
				st_d = ST_NEXT;
			end
			default: st_d = ST_IDLE;
		endcase
		ev[EV_HIT] = hit_now;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hit_q <= WORD_RESET;
			scan_hi_q <= WORD_RESET;
			scan_lo_q <= WORD_RESET;
			chg_hi_q <= WORD_RESET;
			chg_lo_q <= WORD_RESET;
			mode_q <= '0;
			div_q <= '0;
			scan_en_q <= 1'b0;
			stat_q <= '0;
			irq_en_q <= '0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			b_q <= 1'b0;
			r_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bresp_q <= RESP_OKAY;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			st_q <= ST_IDLE;
			ch_q <= '0;
			tads_q <= '0;
			wr_q <= 1'b0;
		end else begin
			hit_q <= hit_d;
			scan_hi_q <= scan_hi_d;
			scan_lo_q <= scan_lo_d;
			chg_hi_q <= chg_hi_d;
			chg_lo_q <= chg_lo_d;
			mode_q <= mode_d;
			div_q <= div_d;
			scan_en_q <= scan_en_d;
			stat_q <= stat_d;
			irq_en_q <= irq_en_d;
			aw_q <= aw_d;
			w_q <= w_d;
			b_q <= b_d;
			r_q <= r_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			st_q <= st_d;
			ch_q <= ch_d;
			tads_q <= tads_d;
			wr_q <= wr_d;
		end
	end

	// one write and one read in flight
	assign s_axi_awready = !aw_q && !b_q;
	assign s_axi_wready  = !w_q && !b_q;
	assign s_axi_bvalid  = b_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !r_q;
	assign s_axi_rvalid  = r_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign channel_o      = ch_q;
	assign discharge_o    = (st_q == ST_DISCHARGE);
	assign sample_o       = (st_q == ST_SAMPLE);
	assign convert_o      = (st_q == ST_CONVERT);
	assign charge_unit_o  = (st_q == ST_CONVERT) && chg_map[ch_q];
	assign result_write_o = wr_q;
	assign irq_o          = |(stat_q & irq_en_q);
endmodule : scan_hit_ctrl

// File: tb/scan_hit_checker.sv
`timescale 1ns/1ns
module scan_hit_checker
	import scan_hit_pkg::*;
(
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [4:0]  channel_o,
	input wire logic        sample_o,
	input wire logic        discharge_o,
	input wire logic        convert_o,
	input wire logic        charge_unit_o,
	input wire logic        result_write_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] rd_addr_q;
	// control is the one word whose bit 16 may read back as one
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_addr_q <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_addr_q <= s_axi_araddr;
		end
	end
	AST_CHARGE_IN_CONVERT: assert property (charge_unit_o |-> convert_o)
		else $error("charge unit outside conversion");
	AST_PHASE_ONEHOT: assert property (
		$onehot0({discharge_o, sample_o, convert_o}))
		else $error("phases overlap");
	AST_DISCHARGE_FIRST: assert property (
		$rose(sample_o) |-> $past(discharge_o))
		else $error("sample without discharge");
	AST_SAMPLE_TO_CONVERT: assert property (
		$rose(convert_o) |-> $past(sample_o))
		else $error("conversion without sample");
	AST_CONVERT_SPAN: assert property (
		$rose(convert_o) |-> convert_o [*8])
		else $error("conversion too short");
	AST_WRITE_AFTER: assert property (
		$fell(convert_o) |-> ##[0:2] result_write_o)
		else $error("no result write");
	AST_CHANNEL_HELD: assert property (
		convert_o && $past(convert_o) |-> $stable(channel_o))
		else $error("channel moved in conversion");
	AST_RVALID_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_RDATA_UPPER: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000
		|| (rd_addr_q == CONTROL_ADDR && s_axi_rdata[31:17] == 15'h0000))
		else $error("upper read bits set");
	cover property ($rose(charge_unit_o));
	cover property (result_write_o);
	cover property (s_axi_rvalid && !s_axi_rready);
endmodule : scan_hit_checker

// File: tb/analog_front_model.sv
`timescale 1ns/1ns
module analog_front_model (
	input  wire logic [4:0]  channel_i,
	output logic      [11:0] result_o,
	output logic      [11:0] low_bound_o,
	output logic      [11:0] high_bound_o
);
	assign result_o = 12'h100 + {3'h0, channel_i, 4'h0};
	// below low bound for channels 0-15, so less-than and outside modes match
	assign low_bound_o = 12'h200;
	assign high_bound_o = 12'h300;
endmodule : analog_front_model

// File: tb/adc_scan_hit_charge_time_unit_select_bench.sv
`timescale 1ns/1ns
module adc_scan_hit_charge_time_unit_select_bench;
	import scan_hit_pkg::*;
	logic              ref_clk_i = 1'b0;
	logic              rst_n_i = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rd;
	logic              aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, cu;
	logic [1:0]        rp;
	logic [4:0]        ch;
	wire logic         aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	wire logic         smp, dis, conv, chg, wr, irq;
	wire logic [1:0]   bresp, rresp;
	wire logic [31:0]  rdata;
	wire logic [4:0]   chan;
	wire logic [11:0]  res, lo, hi;
	int                fail_count = 0, tests_run = 0, ncv;
	logic [ADDR_W-1:0] ra [5] = '{HIT_LOW_ADDR, SCAN_HIGH_ADDR,
		SCAN_LOW_ADDR, CHARGE_HIGH_ADDR, CHARGE_LOW_ADDR};
	logic [15:0]       rm [5] = '{16'hFFFF, 16'h7CFF, 16'hFFFF, 16'h00FF,
		16'hFFFF};
	logic [3:0]        hit_exp = 4'b1001;
	initial forever #50 ref_clk_i = ~ref_clk_i;
	scan_hit_ctrl uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
		.s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_v),
		.s_axi_bready(b_r), .s_axi_araddr(araddr), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_rdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .result_i(res),
		.low_bound_i(lo), .high_bound_i(hi), .channel_o(chan),
		.sample_o(smp), .discharge_o(dis), .convert_o(conv),
		.charge_unit_o(chg), .result_write_o(wr), .irq_o(irq));
	analog_front_model afe (.channel_i(chan), .result_o(res),
		.low_bound_o(lo), .high_bound_o(hi));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge ref_clk_i);
		awaddr <= a;
		wdata <= d;
		aw_v <= 1;
		w_v <= 1;
		b_r <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge ref_clk_i);
			if (!aw_ok && aw_rdy === 1'b1) begin
				aw_ok = 1;
				aw_v <= 0;
			end
			if (!w_ok && w_rdy === 1'b1) begin
				w_ok = 1;
				w_v <= 0;
			end
		end
		while (b_v !== 1'b1) @(posedge ref_clk_i);
		rp = bresp;
		b_r <= 0;
	endtask : wr_reg
	task automatic rd_reg(input logic [ADDR_W-1:0] a);
		@(posedge ref_clk_i);
		araddr <= a;
		ar_v <= 1;
		do @(posedge ref_clk_i); while (ar_rdy !== 1'b1);
		ar_v <= 0;
		// late ready makes the slave hold its answer a cycle
		@(posedge ref_clk_i);
		r_r <= 1;
		do @(posedge ref_clk_i); while (r_v !== 1'b1);
		rd = rdata;
		rp = rresp;
		r_r <= 0;
	endtask : rd_reg
	task automatic convert_one;
		cu = 0;
		ch = '1;
		ncv = 0;
		do begin
			@(posedge ref_clk_i);
			if (conv === 1'b1) begin
				ch = chan;
				ncv++;
				if (chg === 1'b1) cu = 1;
			end
		end while (wr !== 1'b1);
	endtask : convert_one
	task automatic reset_and_masks;
		for (int i = 0; i < 5; i++) begin
			rd_reg(ra[i]);
			check(rd, 32'h0);
			wr_reg(ra[i], 32'hFFFF_FFFF);
			rd_reg(ra[i]);
			check(rd, {16'h0, rm[i]});
			wr_reg(ra[i], 32'h0);
		end
		rd_reg(8'h40);
		check(rp, RESP_SLVERR);
		check(rd, 32'h0);
		wr_reg(8'h40, 32'h1);
		check(rp, RESP_SLVERR);
	endtask : reset_and_masks
	task automatic compare_modes;
		for (int m = 0; m < 4; m++) begin
			wr_reg(HIT_LOW_ADDR, 32'h0);
			wr_reg(CONTROL_ADDR, 32'h0002_0000 | m);
			convert_one();
			check(ch, 5'h00);
			check(cu, 1'b0);
			check(ncv, CONV_TADS);
			rd_reg(HIT_LOW_ADDR);
			check(rd, hit_exp[m]);
		end
	endtask : compare_modes
	task automatic irq_path;
		repeat (2) @(posedge ref_clk_i);
		check(irq, 1'b0);
		wr_reg(IRQ_ENABLE_ADDR, 32'h2);
		repeat (2) @(posedge ref_clk_i);
		check(irq, 1'b1);
		wr_reg(IRQ_CLEAR_ADDR, 32'h7);
		repeat (2) @(posedge ref_clk_i);
		check(irq, 1'b0);
		rd_reg(STATUS_ADDR);
		check(rd & 32'h3, 32'h0);
		rd_reg(HIT_LOW_ADDR);
		check(rd, 32'h1);
		wr_reg(HIT_LOW_ADDR, 32'h0);
		rd_reg(HIT_LOW_ADDR);
		check(rd, 32'h0);
	endtask : irq_path
	task automatic scan_path;
		wr_reg(SCAN_LOW_ADDR, 32'h5);
		wr_reg(CHARGE_LOW_ADDR, 32'h4);
		wr_reg(CONTROL_ADDR, 32'h0003_0103);
		convert_one();
		check(ch, 5'h00);
		check(cu, 1'b0);
		check(ncv, 2 * CONV_TADS);
		convert_one();
		check(ch, 5'h02);
		check(cu, 1'b1);
		rd_reg(HIT_LOW_ADDR);
		check(rd, 32'h5);
	endtask : scan_path
	task automatic tally_and_finish;
		if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	initial begin
		#2000000;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		reset_and_masks();
		compare_modes();
		irq_path();
		scan_path();
		tally_and_finish();
	end
endmodule : adc_scan_hit_charge_time_unit_select_bench
bind scan_hit_ctrl scan_hit_checker chk (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.channel_o(channel_o), .sample_o(sample_o), .discharge_o(discharge_o),
	.convert_o(convert_o), .charge_unit_o(charge_unit_o),
	.result_write_o(result_write_o));
